// file: hw/asr_pkg.sv
// constants and types for the serial port and ready signalling block
// Notes on behaviour
// - output changes on rise, input captured on fall
// - shift input bits on falls while selected
// - shift responses and data out while selected
// - serial output released while deselected
// - ready low marks new data or detection
// - select 00 follows most lagging channel
// - select 01 follows any channel result
// - select 10/11 follows most leading channel
// - global chop ignores source select
// - negative phase may delay first ready
// - above boundary, first ready in first period
// - at or below boundary, first ready delayed
// - boundaries per ratio, none above 1024
// - drive type picks push-pull or open-drain
// - level format holds low until data read
// - pulse format gives short low pulse
// - unread pulse makes next result skipped
// - no ready while data being read
// - sync/reset input syncs or resets device
// - deselect resets interface, ignores serial activity
// - word length 24 after reset
package asr_pkg;
  localparam int NCH        = 8;
  localparam int CH_W       = 3;
  localparam int PHASE_W    = 10;
  localparam int DATA_W     = 24;
  localparam int FIFO_DEPTH = 8;

  localparam logic [5:0] WLEN_16    = 6'h10;
  localparam logic [5:0] WLEN_24    = 6'h18;
  localparam logic [5:0] WLEN_32    = 6'h20;
  localparam logic [5:0] WLEN_RESET = WLEN_24;
  localparam logic [5:0] BIT_ONE    = 6'h01;
  localparam logic [3:0] WORD_LAST  = 4'h8;   // last data word index of a frame
  localparam logic [3:0] WORD_DONE  = 4'h9;

  localparam logic [1:0] SEL_ANY = 2'h1;
  localparam logic [1:0] SEL_LAG = 2'h0;

  localparam logic [2:0] OSR_128  = 3'h0;
  localparam logic [2:0] OSR_256  = 3'h1;
  localparam logic [2:0] OSR_512  = 3'h2;
  localparam logic [2:0] OSR_1024 = 3'h3;
  localparam logic [9:0] BOUND_128  = 10'h3ED;
  localparam logic [9:0] BOUND_256  = 10'h3AD;
  localparam logic [9:0] BOUND_512  = 10'h32D;
  localparam logic [9:0] BOUND_1024 = 10'h22D;

  localparam int CLK_NS         = 40;
  localparam int PULSE_NS       = 160;
  localparam int RESET_LOW_NS   = 20000;
  localparam int PULSE_CYC_INT  = (PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RESET_CYC_INT  = (RESET_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0]  PULSE_CYC = 8'(PULSE_CYC_INT);
  localparam logic [15:0] RESET_CYC = 16'(RESET_CYC_INT);

  typedef struct packed {
    logic [1:0] ready_source_select;
    logic       ready_drive_type;
    logic       ready_format;
    logic       global_chop;
    logic       current_detect;
  } asr_cfg_type;

  typedef logic [NCH-1:0][PHASE_W-1:0] asr_phase_type;

  typedef enum logic [1:0] {
    RDY_IDLE  = 2'b00,
    RDY_LOW   = 2'b01,
    RDY_BRIEF = 2'b10,
    RDY_PULSE = 2'b11
  } asr_rdy_type;

  typedef struct packed {
    logic [2:0] sclk;
    logic [2:0] cs_n;
    logic [2:0] din;
    logic [2:0] syn_n;
    logic       sclk_f;
    logic       cs_n_f;
    logic       din_f;
    logic       syn_n_f;
  } asr_pin_type;

  typedef struct packed {
    asr_pin_type pins;
    logic [31:0] rx;
    logic [31:0] tx;
    logic [5:0]  bit_cnt;
    logic [3:0]  word_cnt;
    logic [5:0]  word_len;
    logic [15:0] cmd_word;
    logic        cmd_valid;
    logic        dout;
    logic        dout_oe_n;
    asr_rdy_type rdy_st;
    logic [7:0]  rdy_cnt;
    logic        rdy_n;
    logic        rdy_oe_n;
    logic        fmt_l;
    logic        drv_l;
    logic        unread;
    logic        first_pend;
    logic        en_d;
    logic [15:0] syn_cnt;
    logic        sync_pulse;
    logic        dev_reset;
  } asr_state_type;
endpackage : asr_pkg

// file: hw/asr_fifo.sv
// conversion data buffer between converter and serial port
`timescale 1ns/1ps
module asr_fifo #(
  parameter int W     = 24,
  parameter int DEPTH = 8
) (
  input  wire logic         clk_i,
  input  wire logic         sys_rst_i,
  input  wire logic         in_valid_i,
  input  wire logic [W-1:0] in_data_i,
  output logic              in_ready_o,
  output logic              out_valid_o,
  output logic [W-1:0]      out_data_o,
  input  wire logic         out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wr;
    logic [AW-1:0]           rd;
    logic [AW:0]             cnt;
    logic                    full;
    logic                    valid;
    logic                    room;
  } asr_fifo_state_type;

  asr_fifo_state_type s;
  asr_fifo_state_type next_s;
  logic push;
  logic pop;

  assign push        = in_valid_i && !s.full;
  assign pop         = out_ready_i && s.valid;
  assign in_ready_o  = s.room;   // registered so the top's ready output comes from a flop
  assign out_valid_o = s.valid;
  assign out_data_o  = s.mem[s.rd];

  // pointer and count update, flags kept registered
  always_comb begin
    next_s = s;
    if (push) begin
      next_s.mem[s.wr] = in_data_i;
      next_s.wr        = AW'(s.wr + 1'b1);
    end
    if (pop) begin
      next_s.rd = AW'(s.rd + 1'b1);
    end
    next_s.cnt   = (AW+1)'(s.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
    next_s.full  = (next_s.cnt == (AW+1)'(DEPTH));
    next_s.valid = (next_s.cnt != '0);
    next_s.room  = !next_s.full;
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      s      <= '0;
      s.room <= 1'b1;
    end else begin
      s <= next_s;
    end
  end
endmodule : asr_fifo

// file: hw/asr_top.sv
// serial slave port with ready output and data buffer
`timescale 1ns/1ps
module asr_top #(
  parameter int FIFO_DEPTH = asr_pkg::FIFO_DEPTH
) (
  input  wire logic                  clk_i,
  input  wire logic                  sys_rst_i,
  input  wire logic                  sclk_i,
  input  wire logic                  cs_n_i,
  input  wire logic                  din_i,
  input  wire logic                  sync_reset_n_i,
  input  wire logic                  conv_enable_i,
  input  wire asr_pkg::asr_cfg_type  cfg_i,
  input  wire logic [2:0]            oversampling_ratio_i,
  input  wire asr_pkg::asr_phase_type channel_phase_setting_i,
  input  wire logic [asr_pkg::NCH-1:0] chan_done_i,
  input  wire logic                  cd_event_i,
  input  wire logic                  wlen_load_i,
  input  wire logic [5:0]            wlen_i,
  input  wire logic                  data_valid_i,
  input  wire logic [asr_pkg::DATA_W-1:0] data_i,
  output logic                       data_ready_o,
  output logic                       dout_o,
  output logic                       dout_oe_n_o,
  output logic                       ready_out_n_o,
  output logic                       ready_oe_n_o,
  output logic [15:0]                cmd_word_o,
  output logic                       cmd_valid_o,
  output logic                       sync_pulse_o,
  output logic                       dev_reset_o
);
  asr_pkg::asr_state_type s;
  asr_pkg::asr_state_type next_s;
  logic                      fifo_valid;
  logic [asr_pkg::DATA_W-1:0] fifo_data;
  logic                      pop;
  logic                      sclk_rise;
  logic                      sclk_fall;
  logic                      cs_active;
  logic                      word_end;
  logic                      data_done;
  logic                      read_start;
  logic [asr_pkg::CH_W-1:0]  ctl;
  logic                      ev;
  logic                      late_first;
  logic                      ev_ok;

  // channel with most leading (lead=1) or most lagging phase
  function automatic logic [asr_pkg::CH_W-1:0] ctl_idx(input asr_pkg::asr_phase_type ph,
                                                        input logic lead);
    logic [asr_pkg::CH_W-1:0] best;
    best = '0;
    for (int i = 1; i < asr_pkg::NCH; i++) begin
      if (lead ? ($signed(ph[i]) < $signed(ph[best])) : ($signed(ph[i]) > $signed(ph[best])))
        best = asr_pkg::CH_W'(i);
    end
    return best;
  endfunction : ctl_idx

  // phase at or below the ratio's boundary pushes the first ready one period out
  function automatic logic past_bound(input logic [9:0] ph, input logic [2:0] oversampling_ratio);
    logic [9:0] b;
    logic       has;
    has = 1'b1;
    b   = asr_pkg::BOUND_128;
    case (oversampling_ratio)
      asr_pkg::OSR_128:  b = asr_pkg::BOUND_128;
      asr_pkg::OSR_256:  b = asr_pkg::BOUND_256;
      asr_pkg::OSR_512:  b = asr_pkg::BOUND_512;
      asr_pkg::OSR_1024: b = asr_pkg::BOUND_1024;
      default:           has = 1'b0;
    endcase
    return has && ($signed(ph) <= $signed(b));
  endfunction : past_bound

  // command sits in the top 16 bits of the received word
  function automatic logic [15:0] cmd_of(input logic [31:0] w, input logic [5:0] wl);
    logic [15:0] c;
    c = w[23:8];
    if (wl == asr_pkg::WLEN_16) c = w[15:0];
    if (wl == asr_pkg::WLEN_32) c = w[31:16];
    return c;
  endfunction : cmd_of

  // data word left aligned: 16-bit drops low byte, 32-bit pads zeros
  function automatic logic [31:0] tx_of(input logic [23:0] d, input logic [5:0] wl);
    return (wl == asr_pkg::WLEN_16) ? {d[23:8], 16'h0000} : {d, 8'h00};
  endfunction : tx_of

  // a pin change counts once the second and third stages agree
  function automatic logic settled(input logic [2:0] v);
    return v[1] == v[2];
  endfunction : settled

  asr_fifo #(
    .W     (asr_pkg::DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .sys_rst_i   (sys_rst_i),
    .in_valid_i  (data_valid_i),
    .in_data_i   (data_i),
    .in_ready_o  (data_ready_o),
    .out_valid_o (fifo_valid),
    .out_data_o  (fifo_data),
    .out_ready_i (pop)
  );

  // serial clock edges found by the system clock
  assign sclk_rise  = settled(s.pins.sclk) && s.pins.sclk[2] && !s.pins.sclk_f;
  assign sclk_fall  = settled(s.pins.sclk) && !s.pins.sclk[2] && s.pins.sclk_f;
  assign cs_active  = !s.pins.cs_n_f;
  assign word_end   = cs_active && sclk_fall && (s.bit_cnt == 6'(s.word_len - asr_pkg::BIT_ONE));
  assign data_done  = word_end && (s.word_cnt == asr_pkg::WORD_LAST);
  assign read_start = word_end && (s.word_cnt == 4'h0);
  assign pop        = word_end && (s.word_cnt < asr_pkg::WORD_LAST) && fifo_valid;

  // ready source: lagging, any, leading; chop and detect bypass the select
  assign ctl = ctl_idx(channel_phase_setting_i, cfg_i.ready_source_select[1]);
  always_comb begin
    if (cfg_i.current_detect) begin
      ev = cd_event_i;
    end else if (cfg_i.global_chop || cfg_i.ready_source_select == asr_pkg::SEL_ANY) begin
      ev = |chan_done_i;
    end else begin
      ev = chan_done_i[ctl];
    end
  end
  assign late_first = !cfg_i.current_detect && !cfg_i.global_chop &&
                      (cfg_i.ready_source_select != asr_pkg::SEL_ANY) &&
                      past_bound(channel_phase_setting_i[ctl], oversampling_ratio_i);
  assign ev_ok = ev && !(s.first_pend && late_first) && !cs_active;

  // next state of the whole block
  always_comb begin
    next_s            = s;
    next_s.cmd_valid  = 1'b0;
    next_s.sync_pulse = 1'b0;
    next_s.dev_reset  = 1'b0;
    next_s.en_d       = conv_enable_i;
    // three-stage pin synchronisers
    next_s.pins.sclk  = {s.pins.sclk[1:0], sclk_i};
    next_s.pins.cs_n  = {s.pins.cs_n[1:0], cs_n_i};
    next_s.pins.din   = {s.pins.din[1:0], din_i};
    next_s.pins.syn_n = {s.pins.syn_n[1:0], sync_reset_n_i};
    if (settled(s.pins.sclk)) next_s.pins.sclk_f = s.pins.sclk[2];
    if (settled(s.pins.cs_n)) next_s.pins.cs_n_f = s.pins.cs_n[2];
    if (settled(s.pins.din)) next_s.pins.din_f = s.pins.din[2];
    if (settled(s.pins.syn_n)) next_s.pins.syn_n_f = s.pins.syn_n[2];
    // serial shifter, counters, tx and dout cleared whenever deselected, rx kept
    if (!cs_active) begin
      next_s.bit_cnt   = '0;
      next_s.word_cnt  = '0;
      next_s.tx        = '0;
      next_s.dout      = 1'b0;
      next_s.dout_oe_n = 1'b1;
    end else begin
      next_s.dout_oe_n = 1'b0;
      if (sclk_rise) begin
        next_s.dout = s.tx[31];
        next_s.tx   = {s.tx[30:0], 1'b0};
      end
      if (sclk_fall) begin
        next_s.rx      = {s.rx[30:0], s.pins.din_f};
        next_s.bit_cnt = 6'(s.bit_cnt + asr_pkg::BIT_ONE);
      end
      if (word_end) begin
        next_s.bit_cnt = '0;
        if (s.word_cnt == 4'h0) begin
          next_s.cmd_word  = cmd_of({s.rx[30:0], s.pins.din_f}, s.word_len);
          next_s.cmd_valid = 1'b1;
        end
        if (s.word_cnt != asr_pkg::WORD_DONE) next_s.word_cnt = 4'(s.word_cnt + 4'h1);
        if (pop) next_s.tx = tx_of(fifo_data, s.word_len);
      end
    end
    if (wlen_load_i && (wlen_i == asr_pkg::WLEN_16 || wlen_i == asr_pkg::WLEN_24 ||
                        wlen_i == asr_pkg::WLEN_32)) begin
      next_s.word_len = wlen_i;
    end
    // short low on sync/reset syncs, long low resets
    if (!s.pins.syn_n_f) begin
      if (s.syn_cnt != asr_pkg::RESET_CYC) next_s.syn_cnt = 16'(s.syn_cnt + 16'h0001);
    end else begin
      next_s.syn_cnt = '0;
      if (s.syn_cnt == asr_pkg::RESET_CYC) next_s.dev_reset = 1'b1;
      else if (s.syn_cnt != '0) next_s.sync_pulse = 1'b1;
    end
    // first event after sync or enable may be pushed out one period
    if (ev) next_s.first_pend = 1'b0;
    if (next_s.sync_pulse || (conv_enable_i && !s.en_d)) next_s.first_pend = 1'b1;
    if (read_start) next_s.unread = 1'b0;
    // ready output sequencing
    unique case (s.rdy_st)
      asr_pkg::RDY_IDLE: begin
        if (ev_ok) begin
          next_s.fmt_l = cfg_i.ready_format;
          next_s.drv_l = cfg_i.ready_drive_type;
          if (!cfg_i.ready_format) begin
            next_s.rdy_st = asr_pkg::RDY_LOW;
            next_s.rdy_n  = 1'b0;
          end else if (s.unread) begin
            next_s.unread = 1'b0;
          end else begin
            next_s.rdy_st  = asr_pkg::RDY_PULSE;
            next_s.rdy_n   = 1'b0;
            next_s.rdy_cnt = asr_pkg::PULSE_CYC;
            next_s.unread  = 1'b1;
          end
        end
      end
      asr_pkg::RDY_LOW: begin
        if (data_done) begin
          next_s.rdy_st = asr_pkg::RDY_IDLE;
          next_s.rdy_n  = 1'b1;
        end else if (ev_ok) begin
          next_s.rdy_st = asr_pkg::RDY_BRIEF;
          next_s.rdy_n  = 1'b1;
        end
      end
      asr_pkg::RDY_BRIEF: begin
        next_s.rdy_st = asr_pkg::RDY_LOW;
        next_s.rdy_n  = 1'b0;
      end
      asr_pkg::RDY_PULSE: begin
        next_s.rdy_cnt = 8'(s.rdy_cnt - 8'h01);
        if (s.rdy_cnt == 8'h01) begin
          next_s.rdy_st = asr_pkg::RDY_IDLE;
          next_s.rdy_n  = 1'b1;
        end
      end
    endcase
    // long sync/reset pulse restores word length, ready sequencing and the unread and first_pend flags
    if (next_s.dev_reset) begin
      next_s.word_len   = asr_pkg::WLEN_RESET;
      next_s.rdy_st     = asr_pkg::RDY_IDLE;
      next_s.rdy_n      = 1'b1;
      next_s.unread     = 1'b0;
      next_s.first_pend = 1'b1;
    end
    next_s.rdy_oe_n = next_s.rdy_n && next_s.drv_l;
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      s              <= '0;
      s.pins.sclk    <= 3'h0;
      s.pins.cs_n    <= 3'h7;
      s.pins.syn_n   <= 3'h7;
      s.pins.cs_n_f  <= 1'b1;
      s.pins.syn_n_f <= 1'b1;
      s.word_len     <= asr_pkg::WLEN_RESET;
      s.dout_oe_n    <= 1'b1;
      s.rdy_st       <= asr_pkg::RDY_IDLE;
      s.rdy_n        <= 1'b1;
      s.first_pend   <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign dout_o        = s.dout;
  assign dout_oe_n_o   = s.dout_oe_n;
  assign ready_out_n_o = s.rdy_n;
  assign ready_oe_n_o  = s.rdy_oe_n;
  assign cmd_word_o    = s.cmd_word;
  assign cmd_valid_o   = s.cmd_valid;
  assign sync_pulse_o  = s.sync_pulse;
  assign dev_reset_o   = s.dev_reset;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_pulse_start;
    s.rdy_st == asr_pkg::RDY_IDLE && ev_ok && cfg_i.ready_format && !s.unread;
  endsequence
  sequence s_pulse_body;
    !ready_out_n_o [*4] ##1 ready_out_n_o;
  endsequence

  property p_release;
    !cs_active |=> dout_oe_n_o;
  endproperty
  a_release: assert property (p_release) else $error("serial output driven while deselected");
  property p_launch;
    cs_active && sclk_rise |=> dout_o == $past(s.tx[31]) && !dout_oe_n_o;
  endproperty
  a_launch: assert property (p_launch) else $error("output bit not launched on rise");
  property p_capture;
    cs_active && sclk_fall |=> s.rx[0] == $past(s.pins.din_f);
  endproperty
  a_capture: assert property (p_capture) else $error("input bit not captured on fall");
  property p_pulse;
    s_pulse_start |=> s_pulse_body;
  endproperty
  a_pulse: assert property (p_pulse) else $error("ready pulse length wrong");
  property p_block;
    ev && cs_active && s.rdy_st == asr_pkg::RDY_IDLE |=> ready_out_n_o;
  endproperty
  a_block: assert property (p_block) else $error("ready asserted during readout");
  property p_drive;
    !ready_out_n_o |-> !ready_oe_n_o;
  endproperty
  a_drive: assert property (p_drive) else $error("ready low but not driven");
  property p_level_done;
    s.rdy_st == asr_pkg::RDY_LOW && data_done |=> ready_out_n_o ##1 ready_out_n_o;
  endproperty
  a_level_done: assert property (p_level_done) else $error("level ready not released");
  property p_skip;
    s.rdy_st == asr_pkg::RDY_IDLE && ev_ok && cfg_i.ready_format && s.unread
      |=> ready_out_n_o && !s.unread;
  endproperty
  a_skip: assert property (p_skip) else $error("unread pulse did not skip a result");
  property p_late_first;
    s.first_pend && late_first && ev && s.rdy_st == asr_pkg::RDY_IDLE |=> ready_out_n_o;
  endproperty
  a_late_first: assert property (p_late_first) else $error("first ready not delayed");
  property p_wlen_reset;
    dev_reset_o |-> s.word_len == asr_pkg::WLEN_24;
  endproperty
  a_wlen_reset: assert property (p_wlen_reset) else $error("word length not 24 after reset");
endmodule : asr_top

// file: test/asr_host.sv
// host side model: serial master that sends frames and collects returned words
`timescale 1ns/1ps
module asr_host (
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      din_o,
  input  wire logic dout_i,
  input  wire logic dout_oe_n_i
);
  logic [31:0] rx [0:8];
  logic        line;

  // a released line floats, so show the inverse of dout, which is held low while released
  assign line = dout_oe_n_i ? ~dout_i : dout_i;

  // clock idles low and select high outside frames
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    din_o  = 1'b0;
  end

  // one frame: command in word 0, zeros after, select held low throughout
  task automatic frame(input logic [15:0] cmd, input int nw, input int wl);
    logic [31:0] sh;
    sh = {cmd, 16'h0000};
    // pins move by non-blocking assignment on system clock edges
    cs_n_o <= 1'b0;
    #200;
    for (int w = 0; w < nw; w++) begin
      rx[w] = 32'h0000_0000;
      for (int b = 0; b < wl; b++) begin
        sclk_o <= 1'b1;
        din_o  <= (w == 0) ? sh[31 - b] : 1'b0;
        #160;
        sclk_o <= 1'b0;
        // sampled late in the low phase: the pin synchroniser delays dout
        #150;
        rx[w] = {rx[w][30:0], line};
        #10;
      end
    end
    #200;
    cs_n_o <= 1'b1;
    din_o  <= ~din_o;
    #400;
  endtask : frame
endmodule : asr_host

// file: test/test_asr_top.sv
// testbench for the serial port and ready signalling block
`timescale 1ns/1ps
module test_asr_top;
  logic                  clk_i = 1'b0;
  logic                  sys_rst_i, sclk, cs_n, din, sync_n, conv_en, cd_ev, wlen_load, dvalid;
  asr_pkg::asr_cfg_type  cfg;
  asr_pkg::asr_phase_type phase;
  logic [2:0]            oversampling_ratio;
  logic [7:0]            chan_done;
  logic [5:0]            wlen;
  logic [23:0]           data;
  logic                  dready, dout, dout_oe_n, rdy_n, rdy_oe_n, cmd_valid, sync_p, dev_rst;
  logic [15:0]           cmd_word;
  logic [9:0]            bnd [0:3];
  logic [2:0]            osrs [0:3];
  logic                  fill;
  int                    n_fail = 0;
  int                    n_compared = 0;
  int                    k;
  int                    n_cmd = 0;
  logic                  drv_lat = 1'b0;

  // 25 MHz system clock
  always #20 clk_i = ~clk_i;

  asr_top DUT (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .sclk_i(sclk), .cs_n_i(cs_n), .din_i(din),
    .sync_reset_n_i(sync_n), .conv_enable_i(conv_en), .cfg_i(cfg),
    .oversampling_ratio_i(oversampling_ratio), .channel_phase_setting_i(phase), .chan_done_i(chan_done),
    .cd_event_i(cd_ev), .wlen_load_i(wlen_load), .wlen_i(wlen), .data_valid_i(dvalid),
    .data_i(data), .data_ready_o(dready), .dout_o(dout), .dout_oe_n_o(dout_oe_n),
    .ready_out_n_o(rdy_n), .ready_oe_n_o(rdy_oe_n), .cmd_word_o(cmd_word),
    .cmd_valid_o(cmd_valid), .sync_pulse_o(sync_p), .dev_reset_o(dev_rst)
  );

  asr_host host (
    .sclk_o(sclk), .cs_n_o(cs_n), .din_o(din), .dout_i(dout), .dout_oe_n_i(dout_oe_n)
  );

  // count command strobes mid-cycle, where the registered pulse is settled
  always @(negedge clk_i) begin
    if (cmd_valid === 1'b1) n_cmd++;
  end

  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop

  // one-cycle result strobe on the chosen channels or detection input
  task automatic ev(input logic [7:0] m, input logic c);
    @(posedge clk_i);
    chan_done <= m;
    cd_ev     <= c;
    @(posedge clk_i);
    chan_done <= 8'h00;
    cd_ev     <= 1'b0;
  endtask : ev

  // count low cycles of the ready output over a short window
  task automatic watch(input int exp);
    int lows;
    lows = 0;
    repeat (8) begin
      #1;
      if (rdy_n === 1'b0) lows++;
      chk(rdy_oe_n, rdy_n & drv_lat, "ready enable");
      @(posedge clk_i);
    end
    chk(lows, exp, "ready low cycles");
  endtask : watch

  // set source, drive, chop, detect with pulse format, then one event
  task automatic sel_case(input logic [1:0] s, input logic dr, input logic ch, input logic cd,
                          input logic [7:0] m, input logic ce, input logic exp);
    @(posedge clk_i);
    cfg <= {s, dr, 1'b1, ch, cd};
    // drive type only takes hold when an event is accepted while ready is idle
    if (exp) drv_lat = dr;
    ev(m, ce);
    watch(exp ? 4 : 0);
    if (exp) host.frame(16'h0000, 1, 24);
  endtask : sel_case

  // short or long low on the sync pin, waiting for the matching pulse
  task automatic sync_low(input int n, input logic long_low);
    logic seen;
    seen = 1'b0;
    @(posedge clk_i);
    sync_n <= 1'b0;
    repeat (n) @(posedge clk_i);
    sync_n <= 1'b1;
    repeat (30) begin
      @(posedge clk_i);
      #1;
      if ((long_low ? dev_rst : sync_p) === 1'b1) seen = 1'b1;
    end
    chk(seen, 1'b1, "sync pin pulse");
  endtask : sync_low

  // main sequence
  initial begin
    bnd  = '{asr_pkg::BOUND_128, asr_pkg::BOUND_256, asr_pkg::BOUND_512, asr_pkg::BOUND_1024};
    osrs = '{asr_pkg::OSR_128, asr_pkg::OSR_256, asr_pkg::OSR_512, asr_pkg::OSR_1024};
    sys_rst_i = 1'b1; sync_n = 1'b1; conv_en = 1'b1; cfg = '0; oversampling_ratio = 3'h4; phase = '0;
    chan_done = 8'h00; cd_ev = 1'b0; wlen_load = 1'b0; wlen = 6'h18; dvalid = 1'b0;
    data = 24'h00_0000;
    repeat (20) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    #1;
    chk(dout_oe_n, 1'b1, "dout released");
    chk(rdy_oe_n, 1'b0, "push-pull default");
    // fill the buffer until it refuses
    k = 0;
    for (int i = 0; i < 10; i++) begin
      #1;
      fill = dready;
      if (fill === 1'b1) k++;
      @(posedge clk_i);
      dvalid <= fill;
      data   <= 24'hC3_A500 + 24'(i);
      @(posedge clk_i);
      dvalid <= 1'b0;
    end
    chk(k, 8, "buffer depth");
    // level format: held low until the data words are read
    ev(8'h01, 1'b0);
    watch(8);
    host.frame(16'hA5C3, 9, 24);
    chk(cmd_word, 16'hA5C3, "command word");
    chk(n_cmd, 1, "command strobe count");
    chk(host.rx[0], 32'h0000_0000, "response word");
    for (int i = 1; i < 9; i++) chk(host.rx[i], 32'hC3_A500 + 32'(i - 1), "data word");
    repeat (3) @(posedge clk_i);
    #1;
    chk(rdy_n, 1'b1, "ready released after read");
    chk(dout_oe_n, 1'b1, "dout released after frame");
    chk(dready, 1'b1, "buffer drained");
    // 16-bit words carry the top of each sample
    @(posedge clk_i);
    dvalid <= 1'b1; data <= 24'hBE_EF12; wlen_load <= 1'b1; wlen <= 6'h10;
    @(posedge clk_i);
    dvalid <= 1'b0; wlen_load <= 1'b0;
    host.frame(16'h1234, 2, 16);
    chk(host.rx[1], 32'h0000_BEEF, "short word data");
    chk(cmd_word, 16'h1234, "short word command");
    chk(n_cmd, 2, "short word strobe count");
    @(posedge clk_i);
    wlen_load <= 1'b1; wlen <= 6'h18;
    cfg.ready_format <= 1'b1;
    @(posedge clk_i);
    wlen_load <= 1'b0;
    // pulse format, then an unread result is skipped
    ev(8'h01, 1'b0);
    watch(4);
    ev(8'h01, 1'b0);
    watch(0);
    ev(8'h01, 1'b0);
    watch(4);
    host.frame(16'h0000, 1, 24);
    // a result arriving during readout gives no pulse
    fork
      host.frame(16'h0F0F, 2, 24);
      begin
        #4000;
        ev(8'h01, 1'b0);
        watch(0);
      end
    join
    // source selection, chop and detect modes
    phase[3] <= 10'h3F0;
    phase[5] <= 10'h010;
    sel_case(2'h0, 1'b0, 1'b0, 1'b0, 8'h08, 1'b0, 1'b0);
    sel_case(2'h0, 1'b0, 1'b0, 1'b0, 8'h20, 1'b0, 1'b1);
    sel_case(2'h2, 1'b1, 1'b0, 1'b0, 8'h20, 1'b0, 1'b0);
    sel_case(2'h2, 1'b1, 1'b0, 1'b0, 8'h08, 1'b0, 1'b1);
    sel_case(2'h3, 1'b0, 1'b0, 1'b0, 8'h08, 1'b0, 1'b1);
    sel_case(2'h1, 1'b1, 1'b0, 1'b0, 8'h02, 1'b0, 1'b1);
    sel_case(2'h0, 1'b0, 1'b1, 1'b0, 8'h02, 1'b0, 1'b1);
    sel_case(2'h0, 1'b0, 1'b0, 1'b1, 8'h20, 1'b0, 1'b0);
    sel_case(2'h0, 1'b0, 1'b0, 1'b1, 8'h00, 1'b1, 1'b1);
    // first ready after enable at and just above each boundary
    cfg <= {2'h0, 1'b0, 1'b1, 1'b0, 1'b0};
    for (int j = 0; j < 4; j++) begin
      for (int t = 0; t < 2; t++) begin
        @(posedge clk_i);
        phase <= {8{bnd[j] + 10'(t)}};
        oversampling_ratio   <= osrs[j];
        conv_en <= 1'b0;
        @(posedge clk_i);
        conv_en <= 1'b1;
        repeat (3) @(posedge clk_i);
        ev(8'h01, 1'b0);
        watch(t ? 4 : 0);
        if (t == 0) begin
          ev(8'h01, 1'b0);
          watch(4);
        end
        host.frame(16'h0000, 1, 24);
      end
    end
    // 32-bit words pad each sample with a zero byte
    @(posedge clk_i);
    dvalid <= 1'b1;
    data <= 24'h5E_A7C1;
    wlen_load <= 1'b1;
    wlen <= 6'h20;
    @(posedge clk_i);
    dvalid <= 1'b0;
    wlen_load <= 1'b0;
    host.frame(16'h5A5A, 2, 32);
    chk(host.rx[1], 32'h5EA7_C100, "long word data");
    chk(cmd_word, 16'h5A5A, "long word command");
    sync_low(20, 1'b0);
    sync_low(520, 1'b1);
    // a long sync low must bring back 24-bit words
    host.frame(16'h6C6C, 1, 24);
    chk(cmd_word, 16'h6C6C, "word length back to 24");
    report_and_stop();
  end
endmodule : test_asr_top
